// ===== verilog/acqtc_pkg.sv
// acqtc_pkg: constants, register map and state types of the acquisition
// and trigger controller.
// assumes a single 250 MHz clock and a 32-bit register port with 8-bit address.
package acqtc_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // timing
    localparam int CLK_PERIOD_NS = 4;
    localparam int US_IN_NS      = 1000;
    localparam int CYC_PER_US    = US_IN_NS / CLK_PERIOD_NS;
    localparam logic [7:0] PRE_LAST = 8'(CYC_PER_US - 1);

    ////////////////////////////////////////////////////////////////////////////
    // register byte offsets
    localparam logic [7:0] REG_CTRL  = 8'h00;
    localparam logic [7:0] REG_CMD   = 8'h04;
    localparam logic [7:0] REG_MFC   = 8'h08;
    localparam logic [7:0] REG_BURST = 8'h0C;
    localparam logic [7:0] REG_EXPO  = 8'h10;
    localparam logic [7:0] REG_RATE  = 8'h14;
    localparam logic [7:0] REG_IVAL  = 8'h18;
    localparam logic [7:0] REG_DELAY = 8'h1C;
    localparam logic [7:0] REG_STAT  = 8'h20;

    // control register fields
    localparam int CTL_CAPT   = 0;
    localparam int CTL_RATE   = 1;
    localparam int CTL_IVAL   = 2;
    localparam int CTL_TRIG   = 3;
    localparam int CTL_ORIG   = 4;
    localparam int CTL_POL    = 5;
    localparam int CTL_SEQ_LO = 8;
    localparam int CTL_PAT_LO = 12;

    // command register bits
    localparam int CMD_START = 0;
    localparam int CMD_STOP  = 1;
    localparam int CMD_ABORT = 2;
    localparam int CMD_SOFT  = 3;

    ////////////////////////////////////////////////////////////////////////////
    // reset values and limits
    localparam logic [23:0] EXPO_RST     = 24'h001F40;
    localparam logic [29:0] RATE_MAX_MHZ = 30'h0000EA60;
    localparam logic [29:0] RATE_MIN_MHZ = 30'h000001F4;
    localparam logic [21:0] IVAL_MAX_US  = 22'h1E8480;
    localparam logic [20:0] DELAY_MAX_US = 21'h1E8480;
    localparam logic [29:0] DIVIDEND     = 30'h3B9ACA00;
    localparam logic [21:0] IVAL_RST     = 22'(DIVIDEND / RATE_MAX_MHZ);
    localparam logic [4:0]  DIV_LAST     = 5'h1D;

    // trigger sequences and patterns
    localparam logic [2:0] SEQ_EDGE  = 3'h0;
    localparam logic [2:0] SEQ_LEVEL = 3'h1;
    localparam logic [2:0] SEQ_BURST = 3'h6;

    localparam logic [3:0] PAT_OFF   = 4'h0;
    localparam logic [3:0] PAT_BLACK = 4'h1;
    localparam logic [3:0] PAT_WHITE = 4'h2;
    localparam logic [3:0] PAT_GREYA = 4'h3;
    localparam logic [3:0] PAT_GREYB = 4'h4;
    localparam logic [3:0] PAT_HRAMP = 4'h5;
    localparam logic [3:0] PAT_VRAMP = 4'h6;
    localparam logic [3:0] PAT_GSCAL = 4'h7;
    localparam logic [3:0] PAT_CBAR  = 4'h8;

    localparam logic [7:0] PIX_WHITE = 8'hFF;
    localparam logic [7:0] PIX_GREYA = 8'hAA;
    localparam logic [7:0] PIX_GREYB = 8'h55;

    ////////////////////////////////////////////////////////////////////////////
    // state
    typedef enum logic [2:0] {
        ST_IDLE, ST_WAIT_TRIG, ST_DELAY, ST_EXPOSE, ST_READOUT, ST_GAP
    } acqtc_phase_e;

    typedef struct packed {
        acqtc_phase_e st;
        logic         stream;
        logic         expo;
        logic         rdo;
        logic         stop_p;
        logic [7:0]   pre;
        logic         tick;
        logic [23:0]  tmr;
        logic [23:0]  per;
        logic [7:0]   burst_left;
        logic [15:0]  frames;
        logic [2:0]   tsync;
        logic [15:0]  ctrl;
        logic [15:0]  mfc;
        logic [7:0]   burst;
        logic [23:0]  expo_us;
        logic [29:0]  rate;
        logic [21:0]  ival;
        logic [20:0]  dly;
        logic         busy;
        logic         tgt_rate;
        logic [4:0]   dcnt;
        logic [30:0]  rem;
        logic [29:0]  den;
        logic [29:0]  quo;
        logic [31:0]  rdata;
        logic [7:0]   pix;
        logic         pix_v;
    } acqtc_state_s;

endpackage

// ===== verilog/acqtc_top.sv
// acqtc_top: acquisition start/stop/abort, frame timing, exposure and
// trigger sequencing, and the test pattern selector on the pixel path.
// assumes sensor pixels and frame_done come from logic on clk; the trigger
// pin is asynchronous; the host keeps the stream channel enable itself.
`timescale 1ns/1ps
module acqtc_top
    import acqtc_pkg::*;
#(
    parameter bit COLOUR_VARIANT = 1'b0
) (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [31:0] reg_rdata,
    input  wire logic        hw_trigger_input,
    input  wire logic [7:0]  sensor_pixel,
    input  wire logic        sensor_valid,
    input  wire logic [10:0] pix_x,
    input  wire logic [10:0] pix_y,
    input  wire logic        frame_done,
    output logic             exposure_active,
    output logic             readout_start,
    output logic             stream_active,
    output logic      [7:0]  pixel_out,
    output logic             pixel_valid
);

    acqtc_state_s q;
    acqtc_state_s n;

    logic        cmd_wr;
    logic        trig_lvl;
    logic        trig_edge;
    logic        trig_ev;
    logic        hw_orig;
    logic        manual;
    logic        level_mode;
    logic [2:0]  seq;
    logic [23:0] period;
    logic [30:0] rem_sh;
    logic [31:0] clamp_v;

    ////////////////////////////////////////////////////////////////////////////
    // pattern selector

    function automatic logic [7:0] pat_pix(input logic [3:0]  sel,
                                           input logic [7:0]  sens,
                                           input logic [10:0] x,
                                           input logic [10:0] y);
        logic [7:0] v;
        v = sens;
        case (sel)
            PAT_BLACK: v = 8'h00;
            PAT_WHITE: v = PIX_WHITE;
            PAT_GREYA: v = PIX_GREYA;
            PAT_GREYB: v = PIX_GREYB;
            PAT_HRAMP: v = x[7:0];
            PAT_VRAMP: v = y[7:0];
            PAT_GSCAL: if (!COLOUR_VARIANT) v = {x[9:7], 5'h00};
            PAT_CBAR:  if (COLOUR_VARIANT) v = ~{x[9:7], 5'h1F};
            default:   v = sens;
        endcase
        return v;
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // next state

    always_comb begin
        n         = q;
        n.tick    = 1'b0;
        n.rdo     = 1'b0;
        n.rdata   = 32'h00000000;
        cmd_wr    = reg_wr && (reg_addr == REG_CMD);
        seq       = q.ctrl[CTL_SEQ_LO +: 3];
        hw_orig   = !q.ctrl[CTL_ORIG];
        manual    = q.ctrl[CTL_RATE] || q.ctrl[CTL_IVAL];
        level_mode = q.ctrl[CTL_TRIG] && hw_orig && (seq == SEQ_LEVEL);
        // tsync[0] feeds only tsync[1]; edge logic looks at the later stages
        n.tsync   = {q.tsync[1:0], hw_trigger_input};
        trig_lvl  = q.tsync[1] ^ q.ctrl[CTL_POL];
        trig_edge = trig_lvl && !(q.tsync[2] ^ q.ctrl[CTL_POL]);
        trig_ev   = hw_orig ? trig_edge
                            : (cmd_wr && reg_wdata[CMD_SOFT]);
        period    = manual && ({2'h0, q.ival} > q.expo_us)
                  ? {2'h0, q.ival} : q.expo_us;
        rem_sh    = {q.rem[29:0], DIVIDEND[5'h1D - q.dcnt]};
        clamp_v   = reg_wdata;

        // microsecond time base
        n.pre = q.pre + 8'h01;
        if (q.pre == PRE_LAST) begin
            n.pre  = 8'h00;
            n.tick = 1'b1;
        end
        if (q.tick) begin
            n.tmr = q.tmr + 24'h000001;
            if (q.per != 24'hFFFFFF) n.per = q.per + 24'h000001;
        end

        // register writes
        if (reg_wr) begin
            case (reg_addr)
                REG_CTRL: begin
                    n.ctrl = reg_wdata[15:0];
                    if (q.stream) begin
                        n.ctrl[CTL_RATE] = q.ctrl[CTL_RATE];
                        n.ctrl[CTL_IVAL] = q.ctrl[CTL_IVAL];
                    end
                end
                REG_MFC:   if (!q.stream) n.mfc = reg_wdata[15:0];
                REG_BURST: n.burst = reg_wdata[7:0];
                REG_EXPO:  n.expo_us = reg_wdata[23:0];
                REG_DELAY: begin
                    if (reg_wdata > 32'(DELAY_MAX_US)) clamp_v = 32'(DELAY_MAX_US);
                    n.dly = clamp_v[20:0];
                end
                REG_RATE: if (!q.stream) begin
                    if (reg_wdata > 32'(RATE_MAX_MHZ)) clamp_v = 32'(RATE_MAX_MHZ);
                    if (reg_wdata < 32'(RATE_MIN_MHZ)) clamp_v = 32'(RATE_MIN_MHZ);
                    n.rate     = clamp_v[29:0];
                    n.den      = clamp_v[29:0];
                    n.tgt_rate = 1'b0;
                    n.busy     = 1'b1;
                    n.dcnt     = 5'h00;
                    n.rem      = '0;
                end
                REG_IVAL: if (!q.stream) begin
                    if (reg_wdata > 32'(IVAL_MAX_US)) clamp_v = 32'(IVAL_MAX_US);
                    if (reg_wdata == 32'h00000000) clamp_v = 32'h00000001;
                    n.ival     = clamp_v[21:0];
                    n.den      = {8'h00, clamp_v[21:0]};
                    n.tgt_rate = 1'b1;
                    n.busy     = 1'b1;
                    n.dcnt     = 5'h00;
                    n.rem      = '0;
                end
                default: ;
            endcase
        end

        // serial divider keeps rate and interval reciprocal
        if (q.busy && !(reg_wr && (reg_addr == REG_RATE || reg_addr == REG_IVAL))) begin
            n.rem  = rem_sh;
            n.quo  = {q.quo[28:0], 1'b0};
            if (rem_sh >= {1'b0, q.den}) begin
                n.rem = rem_sh - {1'b0, q.den};
                n.quo = {q.quo[28:0], 1'b1};
            end
            n.dcnt = q.dcnt + 5'h01;
            if (q.dcnt == DIV_LAST) begin
                n.busy = 1'b0;
                if (!q.tgt_rate) n.ival = n.quo[21:0];
                else if (n.quo > RATE_MAX_MHZ) n.rate = RATE_MAX_MHZ;
                else n.rate = n.quo;
            end
        end

        // register reads, data valid in the following cycle only
        if (reg_rd) begin
            case (reg_addr)
                REG_CTRL:  n.rdata = {16'h0000, q.ctrl};
                REG_MFC:   n.rdata = {16'h0000, q.mfc};
                REG_BURST: n.rdata = {24'h000000, q.burst};
                REG_EXPO:  n.rdata = {8'h00, q.expo_us};
                REG_RATE:  n.rdata = {2'h0, q.rate};
                REG_IVAL:  n.rdata = {10'h000, q.ival};
                REG_DELAY: n.rdata = {11'h000, q.dly};
                REG_STAT:  n.rdata = {q.frames, 12'h000, q.stop_p, q.busy,
                                      q.expo, q.stream};
                default:   n.rdata = 32'h00000000;
            endcase
        end

        if (cmd_wr && reg_wdata[CMD_STOP] && q.stream) n.stop_p = 1'b1;

        ////////////////////////////////////////////////////////////////////////
        // acquisition sequencer
        case (q.st)
            ST_IDLE: begin
                if (cmd_wr && reg_wdata[CMD_START] && !reg_wdata[CMD_ABORT]
                    && !(q.ctrl[CTL_CAPT] && q.mfc == 16'h0000)) begin
                    n.stream = 1'b1;
                    n.stop_p = 1'b0;
                    n.frames = 16'h0000;
                    n.tmr    = 24'h000000;
                    n.per    = 24'h000000;
                    n.st     = q.ctrl[CTL_TRIG] ? ST_WAIT_TRIG : ST_EXPOSE;
                    n.expo   = !q.ctrl[CTL_TRIG];
                end
            end
            ST_WAIT_TRIG: begin
                if (q.stop_p) begin
                    n.st     = ST_IDLE;
                    n.stream = 1'b0;
                end else if (trig_ev) begin
                    n.burst_left = (seq == SEQ_BURST && q.burst != 8'h00)
                                 ? q.burst - 8'h01 : 8'h00;
                    n.tmr = 24'h000000;
                    n.per = 24'h000000;
                    if (hw_orig && q.dly != 21'h000000) begin
                        n.st = ST_DELAY;
                    end else begin
                        n.st   = ST_EXPOSE;
                        n.expo = 1'b1;
                    end
                end
            end
            ST_DELAY: begin
                if (q.stop_p) begin
                    n.st     = ST_IDLE;
                    n.stream = 1'b0;
                end else if (q.tmr > {3'h0, q.dly}) begin
                    n.st   = ST_EXPOSE;
                    n.expo = 1'b1;
                    n.tmr  = 24'h000000;
                    n.per  = 24'h000000;
                end
            end
            ST_EXPOSE: begin
                // count past the setting: the first tick lands at a random phase,
                // so stopping at equality would cut the exposure short
                if (level_mode ? !trig_lvl
                               : (q.tmr > q.expo_us)) begin
                    n.st   = ST_READOUT;
                    n.expo = 1'b0;
                    n.rdo  = 1'b1;
                end
            end
            ST_READOUT: begin
                if (frame_done) begin
                    n.frames = q.frames + 16'h0001;
                    n.tmr    = 24'h000000;
                    if (q.stop_p || (q.ctrl[CTL_CAPT]
                        && n.frames >= q.mfc)) begin
                        n.st     = ST_IDLE;
                        n.stream = 1'b0;
                    end else if (!q.ctrl[CTL_TRIG]) begin
                        n.st = ST_GAP;
                    end else if (q.burst_left != 8'h00) begin
                        n.burst_left = q.burst_left - 8'h01;
                        n.st   = ST_EXPOSE;
                        n.expo = 1'b1;
                        n.per  = 24'h000000;
                    end else begin
                        n.st = ST_WAIT_TRIG;
                    end
                end
            end
            ST_GAP: begin
                if (q.stop_p) begin
                    n.st     = ST_IDLE;
                    n.stream = 1'b0;
                end else if (q.per >= period) begin
                    n.st   = ST_EXPOSE;
                    n.expo = 1'b1;
                    n.tmr  = 24'h000000;
                    n.per  = 24'h000000;
                end
            end
            default: n.st = ST_IDLE;
        endcase

        if (cmd_wr && reg_wdata[CMD_ABORT]) begin
            n.st     = ST_IDLE;
            n.stream = 1'b0;
            n.expo   = 1'b0;
            n.rdo    = 1'b0;
            n.stop_p = 1'b0;
        end

        // pixel path, valid gated by the stream
        n.pix   = pat_pix(q.ctrl[CTL_PAT_LO +: 4], sensor_pixel, pix_x, pix_y);
        n.pix_v = sensor_valid && q.stream;
    end

    ////////////////////////////////////////////////////////////////////////////
    // state register

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            q         <= '0;
            q.expo_us <= EXPO_RST;
            q.rate    <= RATE_MAX_MHZ;
            q.ival    <= IVAL_RST;
        end else begin
            q <= n;
        end
    end

    assign reg_rdata       = q.rdata;
    assign exposure_active = q.expo;
    assign readout_start   = q.rdo;
    assign stream_active   = q.stream;
    assign pixel_out       = q.pix;
    assign pixel_valid     = q.pix_v;

    ////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    no_frames_idle_a: assert property (!q.stream |=> !pixel_valid)
        else $error("pixel valid without an active stream");
    start_run_a: assert property (q.st == ST_IDLE && cmd_wr
        && reg_wdata[CMD_START] && !reg_wdata[CMD_ABORT] && !q.ctrl[CTL_CAPT]
        |=> stream_active)
        else $error("start command did not open the stream");
    abort_now_a: assert property (cmd_wr && reg_wdata[CMD_ABORT]
        |=> !stream_active && !exposure_active)
        else $error("abort left the stream running");
    count_end_a: assert property (q.stream && q.ctrl[CTL_CAPT]
        |-> q.frames < q.mfc)
        else $error("counted capture ran past its frame count");
    rate_lock_a: assert property (q.stream && reg_wr && reg_addr == REG_RATE
        |=> $stable(q.rate))
        else $error("frame rate changed while streaming");
    edge_expose_a: assert property (q.st == ST_EXPOSE && !level_mode
        && q.tmr <= q.expo_us && !cmd_wr |=> exposure_active)
        else $error("exposure ended before its programmed time");
    level_hold_a: assert property (q.st == ST_EXPOSE && level_mode
        && trig_lvl && !cmd_wr |=> exposure_active)
        else $error("level exposure ended while trigger active");
    gap_hold_a: assert property (q.st == ST_GAP && q.per < period
        |=> !exposure_active)
        else $error("exposure started before the frame period");
    delay_hold_a: assert property (q.st == ST_DELAY && q.tmr <= {3'h0, q.dly}
        && !cmd_wr && !q.stop_p |=> q.st == ST_DELAY)
        else $error("trigger delay cut short");
    white_pix_a: assert property (q.ctrl[CTL_PAT_LO +: 4] == PAT_WHITE
        && sensor_valid && q.stream |=> pixel_out == PIX_WHITE && pixel_valid)
        else $error("white pattern pixel wrong");

    run_freerun_c: cover property (q.st == ST_GAP ##[1:1000] q.st == ST_EXPOSE);
    run_burst_c: cover property (q.st == ST_READOUT && frame_done
        && q.burst_left != 8'h00);
    run_count_c: cover property (q.stream && q.ctrl[CTL_CAPT] ##1 !q.stream);

endmodule

// ===== tb/acqtc_far_model.sv
// acqtc_far_model: readout side beyond the sequencer; answers every
// readout_start with one frame_done pulse after a short or long transfer.
// assumes readout_start is a one-cycle pulse on clk.
`timescale 1ns/1ps
module acqtc_far_model (
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic readout_start,
    input  wire logic slow,
    output logic      frame_done
);
    int cnt;
    // host channel is taken as open before start and closed before stop
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cnt        <= 0;
            frame_done <= 1'b0;
        end else begin
            frame_done <= (cnt == 1);
            if (readout_start)
                cnt <= slow ? 40 : 4;
            else if (cnt != 0)
                cnt <= cnt - 1;
        end
    end
endmodule

// ===== tb/tb.sv
// tb: self-checking bench for acqtc_top with a readout partner model.
// assumes the mono variant and the register map of acqtc_pkg.
`timescale 1ns/1ps
module tb;
    import acqtc_pkg::*;
    logic        clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, hw = 0, sv = 0, slow = 0;
    logic [7:0]  reg_addr = 0, spix = 0, pixel_out;
    logic [31:0] reg_wdata = 0, reg_rdata, d;
    logic [10:0] px = 0, py = 0;
    logic        frame_done, exposure_active, readout_start, stream_active, pixel_valid;
    int          errors = 0, checks = 0, n, c0, rdo_cnt = 0;
    always #2 clk = ~clk;
    always @(posedge clk) if (readout_start === 1'b1) rdo_cnt++;
    acqtc_top i_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .hw_trigger_input(hw),
        .sensor_pixel(spix), .sensor_valid(sv), .pix_x(px), .pix_y(py),
        .frame_done(frame_done), .exposure_active(exposure_active),
        .readout_start(readout_start), .stream_active(stream_active),
        .pixel_out(pixel_out), .pixel_valid(pixel_valid));
    acqtc_far_model i_far (.clk(clk), .rst_n(rst_n), .readout_start(readout_start),
        .slow(slow), .frame_done(frame_done));
    ////////////////////////////////////////////////////////////////////////////
    task automatic complete_run();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    // one idle cycle after each strobe keeps every strobe a clean pulse
    task automatic wr(logic [7:0] a, logic [31:0] v);
        reg_addr  <= a;
        reg_wdata <= v;
        reg_wr    <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(logic [7:0] a, output logic [31:0] v);
        reg_addr <= a;
        reg_rd   <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
        v = reg_rdata;
    endtask
    task automatic wait_lvl(int w, logic lvl, int lim, output int k);
        k = 0;
        while ((w ? stream_active : exposure_active) !== lvl) begin
            @(posedge clk);
            k++;
            if (k > lim) begin
                errors++;
                complete_run();
            end
        end
    endtask
    function automatic logic [7:0] pix_model(logic [3:0] p, logic [7:0] s, logic [10:0] x,
                                             logic [10:0] y);
        case (p)
            4'h1: return 8'h00;
            4'h2: return 8'hFF;
            4'h3: return 8'hAA;
            4'h4: return 8'h55;
            4'h5: return x[7:0];
            4'h6: return y[7:0];
            4'h7: return {x[9:7], 5'h00};
            default: return s;
        endcase
    endfunction
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        void'($urandom(32'h4604F2CC));
        repeat (4) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rd(REG_EXPO, d); chk("expo_rst", d, 32'd8000);
        rd(REG_IVAL, d); chk("ival_rst", d, 32'(1000000000 / 60000));
        rd(8'h24, d); chk("unmapped", d, 32'h0);
        chk("no_stream", stream_active, 1'b0);
        wr(REG_RATE, 32'd100);
        rd(REG_RATE, d); chk("rate_min", d, 32'd500);
        repeat (40) @(posedge clk);
        rd(REG_IVAL, d); chk("ival_recip", d, 32'(1000000000 / 500));
        wr(REG_EXPO, 32'd2);
        wr(REG_CMD, 32'h1);
        chk("started", stream_active, 1'b1);
        wait_lvl(0, 1'b0, 1000, n); chk("expo_len", 32'(n >= 480 && n <= 760), 1);
        wr(REG_RATE, 32'd1000);
        rd(REG_RATE, d); chk("rate_frozen", d, 32'd500);
        for (int p = 0; p < 9; p++) begin
            wr(REG_CTRL, 32'(p) << CTL_PAT_LO);
            spix <= 8'($urandom);
            px   <= 11'($urandom);
            py   <= 11'($urandom);
            sv   <= 1'b1;
            @(posedge clk);
            @(posedge clk);
            chk("pixel", pixel_out, pix_model(4'(p), spix, px, py));
            chk("pix_valid", pixel_valid, 1'b1);
        end
        wr(REG_CMD, 32'h2);
        wait_lvl(1, 1'b0, 3000, n); chk("stopped", stream_active, 1'b0);
        slow <= 1'b1;
        wr(REG_MFC, 32'd2);
        wr(REG_CTRL, 32'h1);
        c0 = rdo_cnt;
        wr(REG_CMD, 32'h1);
        wait_lvl(1, 1'b0, 10000, n); chk("mfc_frames", 32'(rdo_cnt - c0), 32'd2);
        wr(REG_CTRL, 32'h0);
        wr(REG_CMD, 32'h1);
        repeat (50) @(posedge clk);
        wr(REG_CMD, 32'h4);
        chk("aborted", {stream_active, exposure_active}, 2'b00);
        wr(REG_DELAY, 32'd1);
        wr(REG_CTRL, 32'h8);
        wr(REG_CMD, 32'h1);
        repeat (5) @(posedge clk);
        chk("trig_wait", exposure_active, 1'b0);
        hw <= 1'b1;
        wait_lvl(0, 1'b1, 1000, n); chk("trig_dly", 32'(n >= 250 && n <= 510), 1);
        wait_lvl(0, 1'b0, 1000, n);
        hw <= 1'b0;
        wr(REG_CMD, 32'h4);
        wr(REG_CTRL, 32'h28);
        wr(REG_CMD, 32'h1);
        hw <= 1'b1;
        repeat (600) @(posedge clk);
        chk("fall_only", exposure_active, 1'b0);
        hw <= 1'b0;
        wait_lvl(0, 1'b1, 1000, n); chk("fall_dly", 32'(n >= 250 && n <= 510), 1);
        wait_lvl(0, 1'b0, 1000, n);
        wr(REG_CMD, 32'h4);
        wr(REG_DELAY, 32'd0);
        wr(REG_CTRL, 32'h108);
        wr(REG_CMD, 32'h1);
        hw <= 1'b1;
        wait_lvl(0, 1'b1, 1000, n);
        repeat (1000) @(posedge clk);
        chk("level_hold", exposure_active, 1'b1);
        hw <= 1'b0;
        wait_lvl(0, 1'b0, 8, n); chk("level_end", exposure_active, 1'b0);
        wr(REG_CMD, 32'h4);
        wr(REG_BURST, 32'd2);
        wr(REG_CTRL, 32'h618);
        wr(REG_CMD, 32'h1);
        c0 = rdo_cnt;
        wr(REG_CMD, 32'h8);
        repeat (6000) @(posedge clk);
        chk("burst_frames", 32'(rdo_cnt - c0), 32'd2);
        wr(REG_CMD, 32'h4);
        complete_run();
    end
endmodule
